// [smon_core.sv]
`timescale 1ns/1ps
// smon_core: monitor-mode entry, vector steering and command interpreter
// assumes pins synchronous to clk_sys_in and a byte memory port with
// combinational read data, valid with the strobe, supplied by the surrounding chip
module smon_core
	import smon_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        arst_n_in,
	input  wire logic        por_in,
	input  wire logic        hv_entry_in,
	input  wire logic        entry_pin_high_in,
	input  wire logic        rx_pin_in,
	input  wire logic        tx_pin_level_in,
	input  wire logic [7:0]  rst_vec_hi_in,
	input  wire logic [7:0]  rst_vec_lo_in,
	input  wire logic        swi_fetch_in,
	input  wire logic        swi_lo_in,
	input  wire logic [7:0]  mem_rdata_in,
	input  wire logic [15:0] sp_in,
	output logic             tx_pin_out,
	output logic             monitor_mode_out,
	output logic             forced_mode_out,
	output logic             wdog_enable_out,
	output logic             pll_select_out,
	output logic [15:0]      vec_addr_out,
	output logic             mem_rd_out,
	output logic             mem_wr_out,
	output logic [15:0]      mem_addr_out,
	output logic [7:0]       mem_wdata_out,
	output logic             run_out
);
	smon_state_t state;
	smon_state_t next_state;
	logic        entered;
	logic        forced;
	logic [3:0]  cnt;
	logic [7:0]  op;
	logic [15:0] last_addr;
	logic [7:0]  data;
	logic [1:0]  left;
	logic [7:0]  q_byte;
	logic        q_full;
	logic        q_brk;
	logic [15:0] wait_cyc;
	logic        tx_go;
	logic        tx_busy;
	logic        rx_valid;
	logic        rx_brk;
	logic [7:0]  rx_byte;
	logic        uart_tx;
	logic        tx_go_d;
	logic        pll_path;
	wire         erased  = (rst_vec_hi_in == ERASED_BYTE) &&
	                       (rst_vec_lo_in == ERASED_BYTE);
	// forced entry keeps the reference divider, since the pll may not lock
	// latched at entry, so removing the high voltage keeps the link rate
	wire         use_pll = pll_path;
	wire  [15:0] bit_cyc = use_pll ? BIT_CYC_PLL_W : BIT_CYC_REF_W;
	wire         q_free  = !q_full;
	wire         is_op   = (rx_byte == OP_READ) || (rx_byte == OP_WRITE) ||
	                       (rx_byte == OP_INDEXED_READ_CMD) ||
	                       (rx_byte == OP_INDEXED_WRITE_CMD) ||
	                       (rx_byte == OP_STACK_POINTER_READ_CMD) || (rx_byte == OP_RUN);
	wire  [15:0] vec_base = entered ? (swi_fetch_in ? VEC_SWI_MON
	                       : VEC_RST_MON) : (swi_fetch_in ? VEC_SWI_USER
	                       : VEC_RST_USER);
	smon_uart u_uart (
		.clk_sys_in   (clk_sys_in),
		.arst_n_in    (arst_n_in),
		.bit_cyc_in   (bit_cyc),
		.rx_in        (rx_pin_in),
		.tx_out       (uart_tx),
		.tx_go_in     (tx_go),
		.tx_byte_in   (q_byte),
		.tx_brk_in    (q_brk),
		.tx_busy_out  (tx_busy),
		.rx_valid_out (rx_valid),
		.rx_byte_out  (rx_byte),
		.rx_brk_out   (rx_brk)
	);
	assign tx_go = q_full && !tx_busy && !tx_go_d;
	// mode capture after reset release; por clears forced mode
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			entered <= 1'b0; forced <= 1'b0; pll_path <= 1'b0;
		end
		else if (por_in)
		begin
			entered <= 1'b0; forced <= 1'b0; pll_path <= 1'b0;
		end
		else if (!entered && entry_pin_high_in && !tx_pin_level_in)
		begin
			pll_path <= hv_entry_in;
			forced  <= erased && !hv_entry_in;
			entered <= hv_entry_in || erased;
		end
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			monitor_mode_out <= 1'b0; forced_mode_out <= 1'b0;
			wdog_enable_out <= 1'b1; pll_select_out <= 1'b0;
			vec_addr_out <= VEC_RST_USER; tx_pin_out <= 1'b1;
			tx_go_d <= 1'b0;
		end
		else
		begin
			monitor_mode_out <= entered;
			forced_mode_out  <= forced;
			// watchdog returns once the high voltage goes away
			wdog_enable_out  <= !(forced || (entered && hv_entry_in));
			pll_select_out   <= use_pll;
			vec_addr_out     <= {vec_base[15:1], swi_lo_in};
			tx_pin_out       <= uart_tx;
			tx_go_d          <= tx_go;
		end
	always_comb
	begin
		next_state = state;
		unique case (state)
			SM_SECURE:  if (cnt == SEC_BYTES) next_state = SM_BREAK;
			SM_BREAK:   if (q_free) next_state = SM_IDLE;
			SM_IDLE:    if (rx_valid && is_op && q_free)
				next_state = (rx_byte == OP_READ || rx_byte == OP_WRITE)
					? SM_ADDR_HI : (rx_byte == OP_INDEXED_WRITE_CMD) ? SM_DATA
					: (rx_byte == OP_INDEXED_READ_CMD) ? SM_MEM_RD
					: (rx_byte == OP_STACK_POINTER_READ_CMD) ? SM_SEND : SM_IDLE;
			SM_ADDR_HI: if (rx_valid && q_free) next_state = SM_ADDR_LO;
			SM_ADDR_LO: if (rx_valid && q_free)
				next_state = (op == OP_READ) ? SM_MEM_RD : SM_DATA;
			SM_DATA:    if (rx_valid && q_free) next_state = SM_MEM_WR;
			SM_MEM_WR:  next_state = SM_IDLE;
			SM_MEM_RD:  next_state = SM_SEND;
			SM_SEND:    if (q_free) next_state = (left > 2'h1)
				? SM_MEM_RD : SM_IDLE;
			SM_BRK_ECH: if (wait_cyc == 16'h0000 && q_free)
				next_state = SM_IDLE;
			default:    next_state = SM_IDLE;
		endcase
		if (rx_brk && state != SM_SECURE)
			next_state = SM_BRK_ECH;
	end
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			state <= SM_SECURE; cnt <= 4'h0; op <= 8'h00;
			last_addr <= 16'h0000; data <= 8'h00; left <= 2'h0;
			q_byte <= 8'h00; q_full <= 1'b0; q_brk <= 1'b0;
			wait_cyc <= 16'h0000; mem_rd_out <= 1'b0; mem_wr_out <= 1'b0;
			mem_addr_out <= 16'h0000; mem_wdata_out <= 8'h00;
			run_out <= 1'b0;
		end
		else
		begin
			state <= next_state;
			mem_rd_out <= 1'b0;
			mem_wr_out <= 1'b0;
			run_out <= 1'b0;
			if (tx_go_d)
				q_full <= 1'b0;
			if (state == SM_SECURE && rx_valid && cnt != SEC_BYTES)
				cnt <= cnt + 4'h1;
			// echo goes to the one-byte queue before any result, order
			if (rx_valid && state != SM_SECURE && q_free)
			begin
				q_byte <= rx_byte; q_brk <= 1'b0; q_full <= 1'b1;
			end
			unique case (state)
				SM_BREAK: if (q_free)
				begin
					q_brk <= 1'b1; q_full <= 1'b1;
				end
				SM_IDLE: if (rx_valid && q_free)
				begin
					op <= rx_byte;
					run_out <= (rx_byte == OP_RUN);
					left <= (rx_byte == OP_INDEXED_READ_CMD) ? 2'h2 : 2'h1;
					if (rx_byte == OP_INDEXED_READ_CMD)
						last_addr <= last_addr + 16'h0001;
					if (rx_byte == OP_INDEXED_WRITE_CMD)
						last_addr <= last_addr + 16'h0001;
					if (rx_byte == OP_STACK_POINTER_READ_CMD)
						data <= sp_in[15:8];
				end
				SM_ADDR_HI: if (rx_valid && q_free)
					last_addr[15:8] <= rx_byte;
				SM_ADDR_LO: if (rx_valid && q_free)
					last_addr[7:0] <= rx_byte;
				SM_DATA: if (rx_valid && q_free)
					data <= rx_byte;
				SM_MEM_WR:
				begin
					mem_wr_out <= 1'b1; mem_addr_out <= last_addr;
					mem_wdata_out <= data;
				end
				SM_MEM_RD:
				begin
					mem_rd_out <= 1'b1; mem_addr_out <= last_addr;
				end
				SM_SEND: if (q_free)
				begin
					q_byte <= (op == OP_STACK_POINTER_READ_CMD) ? data : mem_rdata_in;
					q_brk <= 1'b0; q_full <= 1'b1;
					left <= left - 2'h1;
					if (left > 2'h1)
						last_addr <= last_addr + 16'h0001;
				end
				SM_BRK_ECH:
					if (wait_cyc != 16'h0000)
						wait_cyc <= wait_cyc - 16'h0001;
					else if (q_free)
					begin
						q_brk <= 1'b1; q_full <= 1'b1;
					end
				default: ;
			endcase
			if (rx_brk && state != SM_SECURE)
				wait_cyc <= 16'(bit_cyc * 16'(BREAK_WAIT_BITS));
		end
endmodule // smon_core

// [smon_pkg.sv]
// smon_pkg: constants for the serial monitor-mode interface
// assumes a 125 MHz system clock; all link timing derives from it
package smon_pkg;
	localparam int unsigned CLK_HZ          = 125000000;
	localparam int unsigned BAUD_PLL        = 9600;
	localparam int unsigned REF_DIV         = 1024;
	localparam int unsigned BIT_CYC_PLL     = CLK_HZ / BAUD_PLL;
	localparam logic [15:0] BIT_CYC_PLL_W   = BIT_CYC_PLL[15:0];
	localparam logic [15:0] BIT_CYC_REF_W   = REF_DIV[15:0];
	localparam logic [3:0]  SEC_BYTES       = 4'h8;
	localparam logic [3:0]  BREAK_BITS      = 4'ha;
	localparam logic [3:0]  BREAK_WAIT_BITS = 4'h2;
	localparam logic [7:0]  OP_READ         = 8'h4a;
	localparam logic [7:0]  OP_WRITE        = 8'h49;
	localparam logic [7:0]  OP_INDEXED_READ_CMD        = 8'h1a;
	localparam logic [7:0]  OP_INDEXED_WRITE_CMD       = 8'h19;
	localparam logic [7:0]  OP_STACK_POINTER_READ_CMD       = 8'h0c;
	localparam logic [7:0]  OP_RUN          = 8'h28;
	localparam logic [15:0] VEC_RST_USER    = 16'hfffe;
	localparam logic [15:0] VEC_RST_MON     = 16'hfefe;
	localparam logic [15:0] VEC_SWI_USER    = 16'hfffc;
	localparam logic [15:0] VEC_SWI_MON     = 16'hfefc;
	localparam logic [7:0]  ERASED_BYTE     = 8'hff;
	typedef enum logic [3:0] {
		SM_SECURE  = 4'h0,
		SM_BREAK   = 4'h1,
		SM_IDLE    = 4'h2,
		SM_ADDR_HI = 4'h3,
		SM_ADDR_LO = 4'h4,
		SM_DATA    = 4'h5,
		SM_MEM_RD  = 4'h6,
		SM_SEND    = 4'h7,
		SM_MEM_WR  = 4'h8,
		SM_BRK_ECH = 4'h9
	} smon_state_t;
endpackage

// [smon_uart.sv]
`timescale 1ns/1ps
// smon_uart: nrz byte transmitter and receiver sharing one bit period
// assumes rx_in is already synchronous to clk_sys_in
module smon_uart
	import smon_pkg::*;
(
	input  wire logic        clk_sys_in,
	input  wire logic        arst_n_in,
	input  wire logic [15:0] bit_cyc_in,
	input  wire logic        rx_in,
	output logic             tx_out,
	input  wire logic        tx_go_in,
	input  wire logic [7:0]  tx_byte_in,
	input  wire logic        tx_brk_in,
	output logic             tx_busy_out,
	output logic             rx_valid_out,
	output logic [7:0]       rx_byte_out,
	output logic             rx_brk_out
);
	logic [15:0] rx_cnt;
	logic [3:0]  rx_bit;
	logic        rx_act;
	logic [8:0]  rx_sh;
	logic        rx_hold;
	logic [15:0] tx_cnt;
	logic [3:0]  tx_bit;
	logic [9:0]  tx_sh;
	wire  [15:0] half_cyc  = {1'b0, bit_cyc_in[15:1]};
	wire         rx_tick   = rx_act && (rx_cnt == 16'h0000);
	wire         rx_last   = rx_tick && (rx_bit == 4'h9);
	wire         tx_tick   = tx_busy_out && (tx_cnt == 16'h0000);
	// frame: low start, eight data lsb first, high stop
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			rx_act <= 1'b0; rx_cnt <= 16'h0000; rx_bit <= 4'h0;
			rx_sh <= 9'h000; rx_valid_out <= 1'b0;
			rx_byte_out <= 8'h00; rx_brk_out <= 1'b0;
			rx_hold <= 1'b0;
		end
		else
		begin
			rx_valid_out <= rx_last && rx_in;
			// a break leaves the line low past its last sample; without
			// this hold the tail would be taken for a new start bit
			if (rx_last && !rx_in)
				rx_hold <= 1'b1;
			else if (rx_in)
				rx_hold <= 1'b0;
			// start plus nine lows with no stop is a break
			rx_brk_out   <= rx_last && !rx_in && (rx_sh == 9'h000);
			if (!rx_act && !rx_in && !rx_hold)
			begin
				rx_act <= 1'b1; rx_cnt <= half_cyc; rx_bit <= 4'h0;
			end
			else if (rx_tick)
			begin
				rx_cnt <= bit_cyc_in - 16'h0001;
				rx_bit <= rx_bit + 4'h1;
				if (rx_bit != 4'h9)
					rx_sh <= {rx_in, rx_sh[8:1]};
				else
				begin
					rx_act <= 1'b0;
					rx_byte_out <= rx_sh[8:1];
				end
			end
			else if (rx_act)
				rx_cnt <= rx_cnt - 16'h0001;
		end
	// the transmitter runs at the receive rate by construction
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
		begin
			tx_out <= 1'b1; tx_busy_out <= 1'b0; tx_cnt <= 16'h0000;
			tx_bit <= 4'h0; tx_sh <= 10'h3ff;
		end
		else if (!tx_busy_out && tx_go_in)
		begin
			tx_busy_out <= 1'b1;
			tx_cnt <= bit_cyc_in - 16'h0001;
			tx_bit <= 4'h0;
			tx_sh <= tx_brk_in ? 10'h000 : {1'b1, tx_byte_in, 1'b0};
			tx_out <= 1'b0;
		end
		else if (tx_tick)
		begin
			tx_cnt <= bit_cyc_in - 16'h0001;
			tx_bit <= tx_bit + 4'h1;
			tx_sh <= {1'b1, tx_sh[9:1]};
			tx_out <= (tx_bit == 4'h9) ? 1'b1 : tx_sh[1];
			if (tx_bit == 4'h9)
				tx_busy_out <= 1'b0;
		end
		else if (tx_busy_out)
			tx_cnt <= tx_cnt - 16'h0001;
endmodule // smon_uart

// [smon_core_properties.sv]
// smon_core_properties: port-level checks on the monitor core
// assumes one clock domain and the bit periods of the package
`timescale 1ns/1ps
module smon_core_properties
	import smon_pkg::*;
(
	input wire logic        clk_sys_in,
	input wire logic        arst_n_in,
	input wire logic        hv_entry_in,
	input wire logic        swi_fetch_in,
	input wire logic        swi_lo_in,
	input wire logic        tx_pin_out,
	input wire logic        monitor_mode_out,
	input wire logic        forced_mode_out,
	input wire logic        wdog_enable_out,
	input wire logic        pll_select_out,
	input wire logic [15:0] vec_addr_out,
	input wire logic        mem_rd_out,
	input wire logic        mem_wr_out
);
	logic [17:0] low_cnt;
	wire  [17:0] bit_len = pll_select_out ? {2'h0, BIT_CYC_PLL_W}
		: {2'h0, BIT_CYC_REF_W};
	// counts low cycles on the transmit pin; cleared by any high cycle
	always_ff @(posedge clk_sys_in or negedge arst_n_in)
		if (!arst_n_in)
			low_cnt <= '0;
		else
			low_cnt <= tx_pin_out ? '0 : low_cnt + 18'h1;
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!arst_n_in);
	a_rst_vec_mon:
		assert property ((monitor_mode_out && !swi_fetch_in && !swi_lo_in)[*2]
			|-> vec_addr_out == VEC_RST_MON) else $error("reset vector page");
	a_swi_vec_mon:
		assert property ((monitor_mode_out && swi_fetch_in && !swi_lo_in)[*2]
			|-> vec_addr_out == VEC_SWI_MON) else $error("swi vector page");
	a_swi_vec_user:
		assert property ((!monitor_mode_out && swi_fetch_in && swi_lo_in)[*2]
			|-> vec_addr_out == VEC_SWI_USER + 16'h1) else $error("swi user");
	a_forced_wdog_off:
		assert property (forced_mode_out && $past(forced_mode_out)
			|-> !wdog_enable_out && monitor_mode_out) else $error("forced wdog");
	a_hv_wdog_drop:
		assert property ($fell(hv_entry_in) && monitor_mode_out
			&& !forced_mode_out |-> ##[1:4] wdog_enable_out)
			else $error("wdog not restored");
	a_rd_one_pulse:
		assert property (mem_rd_out |=> !mem_rd_out && !mem_wr_out)
			else $error("read pulse too long");
	a_rd_after_echo:
		assert property (mem_rd_out |-> tx_pin_out && $past(tx_pin_out))
			else $error("read during echo");
	a_low_run_bound:
		assert property (!tx_pin_out |-> low_cnt < bit_len * 18'ha)
			else $error("low run too long");
	a_bit_edge_align:
		assert property ($rose(tx_pin_out) |-> low_cnt % bit_len == 18'h0)
			else $error("low run not whole bits");
endmodule // smon_core_properties
bind smon_core smon_core_properties u_props (.clk_sys_in, .arst_n_in,
	.hv_entry_in, .swi_fetch_in, .swi_lo_in, .tx_pin_out, .monitor_mode_out,
	.forced_mode_out, .wdog_enable_out, .pll_select_out, .vec_addr_out,
	.mem_rd_out, .mem_wr_out);

// [smon_host.sv]
// smon_host: host end of the monitor link, sends and decodes frames
// assumes the divide-by-1024 bit period; the line idles high
`timescale 1ns/1ps
module smon_host
(
	input  wire logic clk_sys_in,
	input  wire logic line_in,
	output logic      line_out
);
	localparam int BIT = 1024;
	logic [8:0] rx_q [$];
	logic [8:0] sh;
	initial line_out = 1'b1;
	// stop low with zero data makes a break
	task automatic send(input logic [7:0] b, input logic stop);
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clk_sys_in);
			#1 line_out = (i == 0) ? 1'b0 : (i == 9) ? stop : b[i - 1];
			repeat (BIT - 1) @(posedge clk_sys_in);
		end
		@(posedge clk_sys_in);
		#1 line_out = 1'b1;
	endtask
	// samples mid bit; a low stop bit sets bit 8, so a break is logged as 9'h100
	always
	begin
		@(negedge line_in);
		repeat (BIT / 2) @(posedge clk_sys_in);
		for (int i = 0; i < 9; i++)
		begin
			repeat (BIT) @(posedge clk_sys_in);
			sh = {line_in, sh[8:1]};
		end
		rx_q.push_back({~sh[8], sh[7:0]});
		while (line_in !== 1'b1)
			@(posedge clk_sys_in);
	end
endmodule // smon_host

// [serial_monitor_mode_interface_test.sv]
// serial_monitor_mode_interface_test: entry, vectors and link traffic
// assumes the core alone, the host model on its pins and a memory stub
`timescale 1ns/1ps
module serial_monitor_mode_interface_test;
	import smon_pkg::*;
	logic        clk_sys_in    = 1'b0;
	logic        arst_n_in     = 1'b0;
	logic        hv_entry_in   = 1'b0;
	logic [7:0]  rst_vec_hi_in = 8'h00;
	logic [7:0]  rst_vec_lo_in = 8'h00;
	logic        swi_fetch_in  = 1'b0;
	logic        swi_lo_in     = 1'b0;
	logic [15:0] rd_addr       = 16'h0000;
	logic [15:0] wr_addr       = 16'h0000;
	logic [7:0]  wr_data       = 8'h00;
	int          n_errors      = 0;
	int          num_checks    = 0;
	wire logic   rx_pin_in, tx_pin_out, monitor_mode_out, forced_mode_out;
	wire logic   wdog_enable_out, pll_select_out, mem_rd_out;
	wire logic [15:0] vec_addr_out, mem_addr_out;
	wire logic   mem_wr_out;
	wire logic [7:0] mem_wdata_out;
	// memory stub: data follows the low address byte, so a wrong low byte shows
	wire logic [7:0] mem_rdata_in = mem_addr_out[7:0] ^ 8'ha5;
	always #4 clk_sys_in = ~clk_sys_in;
	always @(posedge clk_sys_in)
		if (mem_rd_out === 1'b1)
			rd_addr <= mem_addr_out;
	always @(posedge clk_sys_in)
		if (mem_wr_out === 1'b1)
			{wr_addr, wr_data} <= {mem_addr_out, mem_wdata_out};
	smon_core u_dut (.clk_sys_in, .arst_n_in, .por_in (1'b0), .hv_entry_in,
		.entry_pin_high_in (1'b1), .rx_pin_in, .tx_pin_level_in (1'b0),
		.rst_vec_hi_in, .rst_vec_lo_in, .swi_fetch_in, .swi_lo_in,
		.mem_rdata_in, .sp_in (16'h0000), .tx_pin_out, .monitor_mode_out,
		.forced_mode_out, .wdog_enable_out, .pll_select_out, .vec_addr_out,
		.mem_rd_out, .mem_wr_out, .mem_addr_out, .mem_wdata_out,
		.run_out ());
	smon_host u_host (.clk_sys_in, .line_in (tx_pin_out),
		.line_out (rx_pin_in));
	task automatic chk(input logic ok, input string msg);
		num_checks++;
		if (ok !== 1'b1)
		begin
			n_errors++;
			$display("Error %0t: %s", $time, msg);
		end
	endtask
	task automatic do_reset(input logic hv, input logic [7:0] hi, lo,
		input logic fetch, lo_sel);
		@(posedge clk_sys_in);
		#1 arst_n_in = 1'b0;
		{hv_entry_in, rst_vec_hi_in, rst_vec_lo_in} = {hv, hi, lo};
		{swi_fetch_in, swi_lo_in} = {fetch, lo_sel};
		repeat (4) @(posedge clk_sys_in);
		#1 arst_n_in = 1'b1;
		repeat (6) @(posedge clk_sys_in);
		#1;
	endtask
	task automatic wait_rx(input int n);
		int k = 0;
		while (u_host.rx_q.size() < n && k < 60000)
		begin
			@(posedge clk_sys_in);
			k++;
		end
		if (u_host.rx_q.size() < n)
		begin
			chk(1'b0, "link timeout");
			results();
		end
	endtask
	task automatic t_hv_entry;
		do_reset(1'b1, 8'h12, 8'h34, 1'b1, 1'b0);
		chk(monitor_mode_out === 1'b1 && !forced_mode_out, "hv entry");
		chk(pll_select_out === 1'b1, "pll path");
		chk(wdog_enable_out === 1'b0, "wdog on");
		chk(vec_addr_out === VEC_SWI_MON, "swi page");
		hv_entry_in = 1'b0;
		repeat (5) @(posedge clk_sys_in);
		#1 chk(wdog_enable_out === 1'b1, "wdog off");
		chk(pll_select_out === 1'b1, "pll held");
		$display("test hv entry done");
	endtask
	task automatic t_user;
		do_reset(1'b0, 8'h12, 8'h34, 1'b1, 1'b1);
		chk(monitor_mode_out === 1'b0 && wdog_enable_out, "user");
		chk(vec_addr_out === VEC_SWI_USER + 16'h1, "swi user");
		$display("test user mode done");
	endtask
	task automatic t_forced;
		do_reset(1'b0, ERASED_BYTE, ERASED_BYTE, 1'b0, 1'b0);
		chk(forced_mode_out === 1'b1 && monitor_mode_out, "forced");
		chk(wdog_enable_out === 1'b0, "forced wdog");
		chk(pll_select_out === 1'b0, "divide path");
		chk(vec_addr_out === VEC_RST_MON, "reset page");
		for (int i = 0; i < 8; i++)
			u_host.send(8'h30 + i[7:0], 1'b1);
		chk(u_host.rx_q.size() == 0, "security echoed");
		wait_rx(1);
		chk(u_host.rx_q.pop_front() === 9'h100, "no break");
		$display("test forced entry done");
	endtask
	task automatic t_read;
		u_host.send(OP_READ, 1'b1);
		u_host.send(8'h12, 1'b1);
		u_host.send(8'h34, 1'b1);
		wait_rx(4);
		chk(u_host.rx_q[0] === 9'h04a, "echo op");
		chk(u_host.rx_q[1] === 9'h012, "echo hi");
		chk(u_host.rx_q[2] === 9'h034, "echo lo");
		chk(rd_addr === 16'h1234, "read address");
		chk(u_host.rx_q[3] === 9'h091, "read data");
		u_host.rx_q.delete();
		$display("test read done");
	endtask
	task automatic t_indexed_write_cmd;
		u_host.send(OP_INDEXED_WRITE_CMD, 1'b1);
		u_host.send(8'h5c, 1'b1);
		wait_rx(2);
		repeat (1536) @(posedge clk_sys_in);
		#1 chk(u_host.rx_q.size() == 2, "write returned data");
		chk(u_host.rx_q[0] === 9'h019, "echo indexed_write_cmd op");
		chk(u_host.rx_q[1] === 9'h05c, "echo indexed_write_cmd data");
		chk(wr_addr === 16'h1235, "indexed_write_cmd address");
		chk(wr_data === 8'h5c, "indexed_write_cmd data");
		u_host.rx_q.delete();
		$display("test indexed write done");
	endtask
	task automatic t_break;
		u_host.send(8'h00, 1'b0);
		wait_rx(1);
		chk(u_host.rx_q[0] === 9'h100, "break echo");
		$display("test break done");
	endtask
	task automatic results;
		$display("checks %0d errors %0d", num_checks, n_errors);
		if (n_errors == 0 && num_checks > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	initial
	begin
		t_hv_entry();
		t_user();
		t_forced();
		t_read();
		t_indexed_write_cmd();
		t_break();
		results();
	end
endmodule // serial_monitor_mode_interface_test
